/* File: pkg/vma_defs.svh */
// Register offsets, field positions, reset values and timing counts of the monitor converter
`ifndef VMA_DEFS_SVH
`define VMA_DEFS_SVH

// ------------------------------------------------------------
// Converter and timing
// ------------------------------------------------------------
`define VMA_RES_BITS 10
`define VMA_NOMINAL_CODE 10'h300
`define VMA_AVG_COUNT 16
`define VMA_AVG_SHIFT 4
`define VMA_CLK_PERIOD_NS 5
`define VMA_CONV_TIME_US 711
`define VMA_MEAS_TIME_US 11380
`define VMA_CONV_CYCLES ((`VMA_CONV_TIME_US * 1000) / `VMA_CLK_PERIOD_NS)

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define VMA_REG_CHIPSET_READ 8'h21
`define VMA_REG_SUPPLY_READ 8'h22
`define VMA_REG_REMOTE1_READ 8'h25
`define VMA_REG_LOCAL_READ 8'h26
`define VMA_REG_REMOTE2_READ 8'h27
`define VMA_REG_STATUS 8'h41
`define VMA_REG_LOW_LIMIT 8'h46
`define VMA_REG_HIGH_LIMIT 8'h47
`define VMA_REG_CHAN_SEL 8'h55
`define VMA_REG_CFG2 8'h73

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define VMA_RST_LOW_LIMIT 8'h00
`define VMA_RST_HIGH_LIMIT 8'hFF
`define VMA_RST_CHAN_SEL 8'h00
`define VMA_RST_CFG2 8'h00

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define VMA_CFG2_AVG_OFF 4
`define VMA_CFG2_BYPASS 5
`define VMA_CFG2_SINGLE 6
`define VMA_CHSEL_MSB 7
`define VMA_CHSEL_LSB 5
`define VMA_STAT_LOW 0
`define VMA_STAT_HIGH 1

// ------------------------------------------------------------
// Channel codes
// ------------------------------------------------------------
`define VMA_CH_CHIPSET 3'h1
`define VMA_CH_SUPPLY 3'h2
`define VMA_CH_REMOTE1 3'h5
`define VMA_CH_LOCAL 3'h6
`define VMA_CH_REMOTE2 3'h7

`endif

/* File: pkg/vma_pkg.sv */
// Types shared by the monitor converter control
package vma_pkg;

    typedef logic [2:0] vma_chan_t;

    typedef struct packed {
        logic ptr_wr;
        logic data_wr;
        logic rd;
        logic [7:0] data;
    } vma_reg_req_t;

    typedef enum logic [1:0] {
        VMA_ST_START = 2'b01,
        VMA_ST_BUSY = 2'b10
    } vma_state_t;

endpackage

/* File: core/vma_sar_seq.sv */
// Successive-approximation sequencer for the shared 10-bit converter
`timescale 1ns/100ps
`include "vma_defs.svh"

module vma_sar_seq #(
    parameter int RES_BITS = `VMA_RES_BITS,
    parameter int CONV_CYCLES = `VMA_CONV_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_start,
    input wire logic i_cmp,
    output logic [RES_BITS-1:0] o_dac_code,
    output logic o_done,
    output logic [RES_BITS-1:0] o_result
);

    localparam int STEP = CONV_CYCLES / RES_BITS;

    // Elaboration-time refusal of widths and trial lengths the sequencer cannot serve
    if (RES_BITS != `VMA_RES_BITS || STEP < 4) begin : g_bad_cfg
        $error("vma_sar_seq: unsupported width or conversion time");
    end

    // ------------------------------------------------------------
    // Comparator synchroniser
    // ------------------------------------------------------------
    logic cmp_meta_r;
    logic cmp_sync_r;

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cmp_meta_r <= 1'b0;
            cmp_sync_r <= 1'b0;
        end else begin
            cmp_meta_r <= i_cmp;
            cmp_sync_r <= cmp_meta_r;
        end
    end

    // ------------------------------------------------------------
    // Bit trials
    // ------------------------------------------------------------
    logic busy_r;
    logic [3:0] bit_r;
    logic [31:0] tick_r;
    logic [RES_BITS-1:0] code_r;
    wire step_end = busy_r && (tick_r == 32'(STEP - 1));
    wire last_bit = (bit_r == 4'h0);
    // Keep the trial bit when the input is at or above the trial level
    wire [RES_BITS-1:0] kept = cmp_sync_r ? code_r : (code_r & ~(RES_BITS'(1) << bit_r));
    wire [RES_BITS-1:0] next_trial = kept | (RES_BITS'(1) << (bit_r - 4'h1));

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            busy_r <= 1'b0;
            bit_r <= 4'h0;
            tick_r <= 32'h0;
            code_r <= '0;
            o_done <= 1'b0;
            o_result <= '0;
        end else begin
            o_done <= 1'b0;
            if (!busy_r && i_start) begin
                busy_r <= 1'b1;
                bit_r <= 4'(RES_BITS - 1);
                tick_r <= 32'h0;
                code_r <= RES_BITS'(1) << (RES_BITS - 1);
            end else if (step_end) begin
                tick_r <= 32'h0;
                if (last_bit) begin
                    busy_r <= 1'b0;
                    o_done <= 1'b1;
                    o_result <= kept;
                    code_r <= kept;
                end else begin
                    bit_r <= bit_r - 4'h1;
                    code_r <= next_trial;
                end
            end else if (busy_r) begin
                tick_r <= tick_r + 32'h1;
            end
        end
    end

    assign o_dac_code = code_r;

endmodule // vma_sar_seq

/* File: core/vma_conv_ctrl.sv */
// Converter sequencing, averaging, reading and limit registers and bus alert
`timescale 1ns/100ps
`include "vma_defs.svh"

// Summary of operation
// - All inputs pass one shared multiplexer into one successive-approximation converter giving 10-bit results.
// - A nominal rail input produces code 0x300, three quarters of full scale, leaving overvoltage headroom.
// - With averaging on each conversion takes 711 us and 16 are averaged per reading, about 11.38 ms in all.
// - Bit 4 of the second configuration register turns averaging off so every conversion is stored.
// - Bit 5 of the second configuration register switches the attenuator out of the chipset-rail path.
// - Bit 6 of the second configuration register converts only one chosen channel, once every 711 us.
// - In single-channel mode bits 7:5 of register 0x55 choose the channel by its three-bit code.
// - Besides temperatures, the chipset-rail input and the device's own supply are measured.
// - Each chipset-rail reading is checked against the low and high limits and sets a status bit when outside.
// - A chipset-rail limit violation drives the open-drain alert line low.
// - The alert is released at a status read only when the fault has gone.
module vma_conv_ctrl #(
    parameter int CONV_CYCLES = `VMA_CONV_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire vma_pkg::vma_reg_req_t i_reg_req,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    input wire logic i_cmp,
    output logic [`VMA_RES_BITS-1:0] o_dac_code,
    output logic [2:0] o_mux_sel,
    output logic o_atten_bypass,
    output logic o_alert_o,
    output logic o_alert_oe
);

    // Elaboration-time refusal of a conversion too short for ten bit trials
    if (CONV_CYCLES < 40) begin : g_bad_conv
        $error("vma_conv_ctrl: conversion time too short");
    end

    // ------------------------------------------------------------
    // Channel helpers
    // ------------------------------------------------------------
    function automatic vma_pkg::vma_chan_t next_chan(input vma_pkg::vma_chan_t ch);
        case (ch)
            `VMA_CH_CHIPSET: next_chan = `VMA_CH_SUPPLY;
            `VMA_CH_SUPPLY: next_chan = `VMA_CH_REMOTE1;
            `VMA_CH_REMOTE1: next_chan = `VMA_CH_LOCAL;
            `VMA_CH_LOCAL: next_chan = `VMA_CH_REMOTE2;
            default: next_chan = `VMA_CH_CHIPSET;
        endcase
    endfunction

    function automatic logic chan_legal(input vma_pkg::vma_chan_t ch);
        chan_legal = (ch == `VMA_CH_CHIPSET) || (ch == `VMA_CH_SUPPLY) || (ch == `VMA_CH_REMOTE1)
            || (ch == `VMA_CH_LOCAL) || (ch == `VMA_CH_REMOTE2);
    endfunction

    // ------------------------------------------------------------
    // Register pointer and writable registers
    // ------------------------------------------------------------
    logic [7:0] ptr_r;
    logic [7:0] low_lim_r;
    logic [7:0] high_lim_r;
    logic [7:0] chan_sel_r;
    logic [7:0] cfg2_r;
    wire wr_low = i_reg_req.data_wr && (ptr_r == `VMA_REG_LOW_LIMIT);
    wire wr_high = i_reg_req.data_wr && (ptr_r == `VMA_REG_HIGH_LIMIT);
    wire wr_sel = i_reg_req.data_wr && (ptr_r == `VMA_REG_CHAN_SEL);
    wire wr_cfg2 = i_reg_req.data_wr && (ptr_r == `VMA_REG_CFG2);
    wire avg_off = cfg2_r[`VMA_CFG2_AVG_OFF];
    wire single_mode = cfg2_r[`VMA_CFG2_SINGLE];
    wire [2:0] sel_code = chan_sel_r[`VMA_CHSEL_MSB:`VMA_CHSEL_LSB];

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ptr_r <= 8'h00;
            low_lim_r <= `VMA_RST_LOW_LIMIT;
            high_lim_r <= `VMA_RST_HIGH_LIMIT;
            chan_sel_r <= `VMA_RST_CHAN_SEL;
            cfg2_r <= `VMA_RST_CFG2;
        end else begin
            if (i_reg_req.ptr_wr) begin
                ptr_r <= i_reg_req.data;
            end
            if (wr_low) begin
                low_lim_r <= i_reg_req.data;
            end
            if (wr_high) begin
                high_lim_r <= i_reg_req.data;
            end
            if (wr_sel) begin
                chan_sel_r <= i_reg_req.data;
            end
            if (wr_cfg2) begin
                cfg2_r <= i_reg_req.data;
            end
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencing
    // ------------------------------------------------------------
    vma_pkg::vma_state_t state_r;
    vma_pkg::vma_chan_t cur_ch_r;
    logic [3:0] avg_cnt_r;
    logic [13:0] acc_r;
    logic sar_done;
    logic [`VMA_RES_BITS-1:0] sar_result;
    wire sar_start = (state_r == vma_pkg::VMA_ST_START);
    wire store = sar_done && (avg_off || (avg_cnt_r == 4'(`VMA_AVG_COUNT - 1)));
    wire [13:0] acc_sum = acc_r + 14'(sar_result);
    wire [`VMA_RES_BITS-1:0] avg_value = avg_off ? sar_result : acc_sum[13:`VMA_AVG_SHIFT];
    // Single mode falls back to the chipset rail on an unused select code
    wire vma_pkg::vma_chan_t meas_ch = single_mode ? (chan_legal(sel_code) ? sel_code : `VMA_CH_CHIPSET)
        : next_chan(cur_ch_r);

    vma_sar_seq #(
        .RES_BITS(`VMA_RES_BITS),
        .CONV_CYCLES(CONV_CYCLES)
    ) u_sar (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_start(sar_start),
        .i_cmp(i_cmp),
        .o_dac_code(o_dac_code),
        .o_done(sar_done),
        .o_result(sar_result)
    );

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r <= vma_pkg::VMA_ST_START;
            cur_ch_r <= `VMA_CH_CHIPSET;
            avg_cnt_r <= 4'h0;
            acc_r <= 14'h0;
        end else begin
            unique case (state_r)
                vma_pkg::VMA_ST_START: state_r <= vma_pkg::VMA_ST_BUSY;
                vma_pkg::VMA_ST_BUSY: begin
                    if (sar_done) begin
                        state_r <= vma_pkg::VMA_ST_START;
                        avg_cnt_r <= store ? 4'h0 : avg_cnt_r + 4'h1;
                        acc_r <= store ? 14'h0 : acc_sum;
                        if (store) begin
                            cur_ch_r <= meas_ch;
                        end
                    end
                end
                default: state_r <= vma_pkg::VMA_ST_START;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Reading storage
    // ------------------------------------------------------------
    logic [`VMA_RES_BITS-1:0] reading_r [8];
    // The 0x300 nominal point is set by the analog scaling; all ten bits are kept
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int i = 0; i < 8; i++) begin
                reading_r[i] <= '0;
            end
        end else if (store) begin
            reading_r[cur_ch_r] <= avg_value;
        end
    end

    // ------------------------------------------------------------
    // Limit checks, status and alert
    // ------------------------------------------------------------
    logic [1:0] status_r;
    logic [1:0] fault_r;
    wire chip_store = store && (cur_ch_r == `VMA_CH_CHIPSET);
    wire [7:0] chip_msb = avg_value[9:2];
    wire [1:0] viol = {chip_msb > high_lim_r, chip_msb < low_lim_r};
    wire [1:0] new_fault = chip_store ? viol : fault_r;
    wire stat_rd = i_reg_req.rd && (ptr_r == `VMA_REG_STATUS);
    // A read clears only bits whose fault has gone; a new violation always wins
    wire [1:0] status_nxt = stat_rd ? (new_fault | (status_r & fault_r)) : (status_r | (chip_store ? viol : 2'b00));

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            status_r <= 2'b00;
            fault_r <= 2'b00;
        end else begin
            fault_r <= new_fault;
            status_r <= status_nxt;
        end
    end

    assign o_alert_o = 1'b0;
    assign o_alert_oe = |status_r;
    assign o_mux_sel = cur_ch_r;
    assign o_atten_bypass = cfg2_r[`VMA_CFG2_BYPASS];

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        unique case (ptr_r)
            `VMA_REG_CHIPSET_READ: rd_mux = reading_r[`VMA_CH_CHIPSET][9:2];
            `VMA_REG_SUPPLY_READ: rd_mux = reading_r[`VMA_CH_SUPPLY][9:2];
            `VMA_REG_REMOTE1_READ: rd_mux = reading_r[`VMA_CH_REMOTE1][9:2];
            `VMA_REG_LOCAL_READ: rd_mux = reading_r[`VMA_CH_LOCAL][9:2];
            `VMA_REG_REMOTE2_READ: rd_mux = reading_r[`VMA_CH_REMOTE2][9:2];
            `VMA_REG_STATUS: rd_mux = {6'h00, status_r};
            `VMA_REG_LOW_LIMIT: rd_mux = low_lim_r;
            `VMA_REG_HIGH_LIMIT: rd_mux = high_lim_r;
            `VMA_REG_CHAN_SEL: rd_mux = chan_sel_r;
            `VMA_REG_CFG2: rd_mux = cfg2_r;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rd_data <= 8'h00;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_reg_req.rd;
            if (i_reg_req.rd) begin
                o_rd_data <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);

    sequence s_chip_fault;
        chip_store && (viol != 2'b00);
    endsequence

    chk_mux_held: assert property (state_r == vma_pkg::VMA_ST_BUSY && !sar_done |=> $stable(o_mux_sel))
        else $error("mux select changed during a conversion");
    chk_avg_count: assert property (store && !avg_off |-> avg_cnt_r == 4'hF)
        else $error("averaged reading stored before sixteen conversions");
    chk_avg_off: assert property (sar_done && avg_off |=> reading_r[$past(cur_ch_r)] == $past(sar_result))
        else $error("unaveraged conversion not stored");
    chk_bypass_write: assert property (wr_cfg2 |=> o_atten_bypass == $past(i_reg_req.data[5]))
        else $error("attenuator bypass does not follow configuration");
    chk_single_chan: assert property (store && single_mode && chan_legal(sel_code)
        |=> o_mux_sel == $past(sel_code))
        else $error("single mode converted the wrong channel");
    chk_rr_order: assert property (store && !single_mode && chan_legal(cur_ch_r)
        |=> o_mux_sel == next_chan($past(cur_ch_r)))
        else $error("round-robin order broken");
    chk_fault_alert: assert property (s_chip_fault |=> (status_r != 2'b00) ##0 o_alert_oe)
        else $error("limit violation did not raise status and alert");
    chk_alert_hold: assert property (stat_rd && (fault_r != 2'b00) && !chip_store |=> o_alert_oe)
        else $error("alert released while fault present");
    chk_alert_release: assert property (stat_rd && fault_r == 2'b00 && !chip_store |=> !o_alert_oe)
        else $error("alert not released after fault cleared");
    chk_read_answer: assert property (i_reg_req.rd |=> o_rd_valid ##1 !o_rd_valid || $past(i_reg_req.rd))
        else $error("read answer missing");

endmodule // vma_conv_ctrl

/* File: testbench/vma_sensor_model.sv */
// Analog sensor levels and comparator at the converter input
`timescale 1ns/100ps
module vma_sensor_model (
    input wire logic [2:0] i_mux_sel,
    input wire logic [9:0] i_dac_code,
    input wire logic i_atten_bypass,
    input wire logic [7:0][9:0] i_levels,
    output logic o_cmp
);
    // ------------------------------------------------------------
    // Comparator
    // ------------------------------------------------------------
    // Slot 0 holds the chipset-rail level seen with the attenuator out
    logic [9:0] lvl;
    assign lvl = (i_mux_sel == 3'h1 && i_atten_bypass) ? i_levels[0] : i_levels[i_mux_sel];
    assign o_cmp = (lvl >= i_dac_code);
endmodule // vma_sensor_model

/* File: testbench/voltage_monitor_adc_control_bench.sv */
// Self-checking bench for the monitor converter control
`timescale 1ns/100ps
`include "vma_defs.svh"
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin fails++; \
    $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module voltage_monitor_adc_control_bench;
    localparam int CONV = 40;
    localparam logic [7:0] OFFS [10] = '{8'h21, 8'h22, 8'h25, 8'h26, 8'h27, 8'h46, 8'h47, 8'h55, 8'h73, 8'h30};
    localparam logic [7:0] EXPS [10] = '{8'hC0, 8'hAA, 8'h57, 8'h3C, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
    localparam logic [2:0] CODES [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
    logic i_sys_clk = 1'b0;
    logic i_reset_n = 1'b0;
    vma_pkg::vma_reg_req_t req = '0;
    logic [7:0] rd_data;
    logic rd_valid, cmp, bypass, alert_o, alert_oe;
    logic [9:0] dac;
    logic [2:0] mux;
    logic [7:0][9:0] levels = '0;
    logic [7:0] v;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    int n;

    vma_conv_ctrl #(.CONV_CYCLES(CONV)) dut_u (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_reg_req(req),
        .o_rd_data(rd_data), .o_rd_valid(rd_valid), .i_cmp(cmp), .o_dac_code(dac), .o_mux_sel(mux),
        .o_atten_bypass(bypass), .o_alert_o(alert_o), .o_alert_oe(alert_oe));
    vma_sensor_model sens_u (.i_mux_sel(mux), .i_dac_code(dac), .i_atten_bypass(bypass), .i_levels(levels),
        .o_cmp(cmp));

    always #2.5 i_sys_clk = ~i_sys_clk;

    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Register bus tasks
    // ------------------------------------------------------------
    task automatic step(input vma_pkg::vma_reg_req_t r);
        @(posedge i_sys_clk);
        #1;
        req = r;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        step({3'b100, a});
        step({3'b010, d});
        step('0);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        step({3'b100, a});
        step({3'b001, 8'h00});
        step('0);
        `CHK("rd_valid", 1'b1, rd_valid)
        d = rd_data;
    endtask

    // Cycles one channel stays on the mux, skipping the partial first one
    task automatic dwell(output int cnt);
        logic [2:0] m;
        cnt = 0;
        @(posedge i_sys_clk);
        #1;
        m = mux;
        while (mux === m && cnt < 2000) begin
            @(posedge i_sys_clk);
            #1;
            cnt++;
        end
        m = mux;
        cnt = 0;
        while (mux === m && cnt < 2000) begin
            @(posedge i_sys_clk);
            #1;
            cnt++;
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        levels[0] = 10'h1A4;
        levels[1] = 10'h300;
        levels[2] = 10'h2A8;
        levels[5] = 10'h15C;
        levels[6] = 10'h0F0;
        levels[7] = 10'h3FC;
        repeat (12) @(posedge i_sys_clk);
        #1;
        i_reset_n = 1'b1;
        repeat (4000) @(posedge i_sys_clk);
        for (int i = 0; i < 10; i++) begin
            rd(OFFS[i], v);
            `CHK("register", EXPS[i], v)
        end
        `CHK("alert idle", 1'b0, alert_oe)
        `CHK("alert value", 1'b0, alert_o)
        $display("rows done");
        dwell(n);
        `CHK("averaged dwell", 1'b1, n >= 16 * CONV && n <= 16 * (CONV + 4))
        wr(8'h73, 8'h10);
        dwell(n);
        `CHK("single dwell", 1'b1, n >= CONV && n <= CONV + 4)
        $display("averaging done");
        wr(8'h73, 8'h30);
        repeat (300) @(posedge i_sys_clk);
        #1;
        `CHK("bypass pin", 1'b1, bypass)
        rd(8'h21, v);
        `CHK("bypass reading", 8'h69, v)
        $display("bypass done");
        wr(8'h73, 8'h50);
        for (int i = 0; i < 5; i++) begin
            wr(8'h55, {CODES[i], 5'h00});
            for (int k = 0; k < 3; k++) begin
                repeat (80) @(posedge i_sys_clk);
                #1;
                `CHK("single channel", CODES[i], mux)
            end
        end
        $display("single mode done");
        wr(8'h73, 8'h10);
        wr(8'h47, 8'hB0);
        repeat (300) @(posedge i_sys_clk);
        #1;
        `CHK("alert high", 1'b1, alert_oe)
        rd(8'h41, v);
        `CHK("status high", 8'h02, v)
        repeat (3) @(posedge i_sys_clk);
        #1;
        `CHK("alert held", 1'b1, alert_oe)
        wr(8'h47, 8'hFF);
        repeat (300) @(posedge i_sys_clk);
        rd(8'h41, v);
        `CHK("status kept", 8'h02, v)
        repeat (3) @(posedge i_sys_clk);
        #1;
        `CHK("alert freed", 1'b0, alert_oe)
        rd(8'h41, v);
        `CHK("status clear", 8'h00, v)
        wr(8'h46, 8'hD0);
        repeat (300) @(posedge i_sys_clk);
        rd(8'h41, v);
        `CHK("status low", 8'h01, v)
        `CHK("alert low", 1'b1, alert_oe)
        $display("limits done");
        @(posedge i_sys_clk);
        #1;
        i_reset_n = 1'b0;
        #1;
        `CHK("reset valid", 1'b0, rd_valid)
        `CHK("reset mux", 3'h1, mux)
        `CHK("reset bypass", 1'b0, bypass)
        `CHK("reset alert", 1'b0, alert_oe)
        `CHK("reset dac", 10'h000, dac)
        repeat (2) @(posedge i_sys_clk);
        #1;
        i_reset_n = 1'b1;
        rd(8'h21, v);
        `CHK("reading reset", 8'h00, v)
        rd(8'h46, v);
        `CHK("low limit reset", 8'h00, v)
        $display("reset done");
        conclude();
    end
endmodule // voltage_monitor_adc_control_bench
